// File: verilog/rotate_stack_pkg.sv
// package: register map, opcodes, cycle counts, flag layout and carriers
// assumes a 32-bit APB master and an 8-bit register file
package rotate_stack_pkg;

	localparam int          RF_AW        = 8;
	localparam int          RF_W         = 8;
	localparam int          CNT_W        = 4;

	// register byte offsets
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_OPER    = 8'h04;
	localparam logic [7:0]  ADDR_FLAGS   = 8'h08;
	localparam logic [7:0]  ADDR_SP      = 8'h0C;
	localparam logic [7:0]  ADDR_PC      = 8'h10;
	localparam logic [7:0]  ADDR_STATUS  = 8'h14;
	localparam logic [7:0]  ADDR_RFADDR  = 8'h18;
	localparam logic [7:0]  ADDR_RFDATA  = 8'h1C;

	// field positions
	localparam int          CTRL_START   = 8;
	localparam int          STAT_BUSY    = 0;
	localparam int          STAT_DONE    = 1;
	localparam int          STAT_ILLEGAL = 2;
	localparam int          FLAG_C       = 7;
	localparam int          FLAG_Z       = 6;
	localparam int          FLAG_S       = 5;
	localparam int          FLAG_V       = 4;

	// reset values
	localparam logic [7:0]  FLAGS_RST    = 8'h00;
	localparam logic [15:0] SP_RST       = 16'h0000;
	localparam logic [15:0] PC_RST       = 16'h0000;
	localparam logic [15:0] OPER_RST     = 16'h0000;

	// opcodes
	localparam logic [7:0]  OPC_PUSH_DN  = 8'h82;
	localparam logic [7:0]  OPC_PUSH_UP  = 8'h83;
	localparam logic [7:0]  OPC_CARRY_CL = 8'hCF;
	localparam logic [7:0]  OPC_ROT_L    = 8'h90;
	localparam logic [7:0]  OPC_ROT_LC   = 8'h10;
	localparam logic [7:0]  OPC_ROT_R    = 8'hE0;
	localparam logic [7:0]  OPC_ROT_RC   = 8'hC0;

	// execution lengths in cycles
	localparam logic [CNT_W-1:0] CYC_PUSH = 4'h8;
	localparam logic [CNT_W-1:0] CYC_CLR  = 4'h4;
	localparam logic [CNT_W-1:0] CYC_RET  = 4'h8;
	localparam logic [CNT_W-1:0] CYC_ROT  = 4'h4;
	localparam logic [CNT_W-1:0] CYC_NONE = 4'h0;

	localparam logic [7:0]  SP_STEP      = 8'h02;

	typedef enum logic [1:0] {
		ROT_LEFT,
		ROT_LEFT_C,
		ROT_RIGHT,
		ROT_RIGHT_C
	} rot_kind_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic carry;
		logic zero;
		logic sign;
		logic overflow;
	} rot_flags_t;

endpackage

// File: verilog/rotate_unit.sv
// rotate_unit: combinational one-bit rotate with its flag results
// assumes carryIn is the carry flag before the instruction
`timescale 1ns/1ps
module rotate_unit
	import rotate_stack_pkg::*;
(
	input  wire rot_kind_t  kind,
	input  wire logic [7:0] operand,
	input  wire logic       carryIn,
	output logic [7:0]      result,
	output rot_flags_t      flags
);

	wire       leftward = (kind == ROT_LEFT) || (kind == ROT_LEFT_C);
	wire [7:0] rotL     = {operand[6:0], operand[7]};
	wire [7:0] rotLC    = {operand[6:0], carryIn};
	wire [7:0] rotR     = {operand[0], operand[7:1]};
	wire [7:0] rotRC    = {carryIn, operand[7:1]};

	assign result = (kind == ROT_LEFT)   ? rotL :         // [RULE_07]
	                (kind == ROT_LEFT_C) ? rotLC :        // [RULE_08]
	                (kind == ROT_RIGHT)  ? rotR : rotRC;  // [RULE_09] [RULE_10]

	assign flags.carry    = leftward ? operand[7] : operand[0]; // [RULE_07] [RULE_09]
	assign flags.zero     = (result == 8'h00);                  // [RULE_11]
	assign flags.sign     = result[7];                          // [RULE_12]
	assign flags.overflow = result[7] ^ operand[7];             // [RULE_13]

endmodule

// File: verilog/user_reg_file.sv
// user_reg_file: register file holding user stacks and the internal stack
// assumes one writer per cycle; reads are combinational
`timescale 1ns/1ps
module user_reg_file #(
	parameter int AW    = 8,
	parameter int WIDTH = 8,
	parameter int DEPTH = 1 << AW
)
(
	input  wire logic             mclk,
	input  wire logic             wrEn,
	input  wire logic [AW-1:0]    wrAddr,
	input  wire logic [WIDTH-1:0] wrData,
	input  wire logic [AW-1:0]    rdAddrA,
	output logic [WIDTH-1:0]      rdDataA,
	input  wire logic [AW-1:0]    rdAddrB,
	output logic [WIDTH-1:0]      rdDataB
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge mclk)
	begin
		if (wrEn)
			mem[wrAddr] <= wrData;
	end

	assign rdDataA = mem[rdAddrA];
	assign rdDataB = mem[rdAddrB];

endmodule

// File: verilog/rotate_stack_instr_exec.sv
// rotate_stack_instr_exec: executes user-stack pushes, carry clear,
// subroutine exit and the four rotates, started over APB
// assumes an APB master on mclk; the internal stack is the register file
//
// What this block does
// RULE_01 - down push: decrement pointer, then store source
// RULE_02 - up push: increment pointer, then store source
// RULE_03 - pushes and subroutine exit keep all flags
// RULE_04 - carry clear zeroes carry, others kept
// RULE_05 - exit loads counter from stack, pointer plus two
// RULE_06 - byte at pointer is high, next is low
// RULE_07 - rotate left: bit 7 to bit 0, carry
// RULE_08 - left through carry: carry in, bit 7 out
// RULE_09 - rotate right: bit 0 to bit 7, carry
// RULE_10 - right through carry: carry in, bit 0 out
// RULE_11 - rotates set zero flag on zero result
// RULE_12 - rotates copy result bit 7 to sign
// RULE_13 - overflow when result bit 7 changed
// RULE_14 - rotates keep decimal-adjust and half-carry flags
// RULE_15 - indirect rotate works on pointed register only
`timescale 1ns/1ps
module rotate_stack_instr_exec
	import rotate_stack_pkg::*;
#(
	parameter logic [7:0] SUB_EXIT_OPC = 8'hCE // arbitrary code
)
(
	input  wire logic     mclk,
	input  wire logic     rst_n,
	input  wire apb_req_t apbReq,
	output apb_rsp_t      apbRsp
);

	typedef enum logic [1:0] {
		S_IDLE,
		S_PTR,
		S_EXEC,
		S_WAIT
	} exec_state_t;

	exec_state_t      state_q;
	logic [7:0]       opc_q;
	logic [7:0]       dstOp_q;
	logic [7:0]       srcOp_q;
	logic [CNT_W-1:0] cnt_q;
	logic [7:0]       ptr_q;
	logic [7:0]       pcHi_q;
	logic [7:0]       flags_q;
	logic [15:0]      stackPtr_q;
	logic [15:0]      programCounter_q;
	logic             done_q;
	logic             illegal_q;
	logic [7:0]       ctrlOpc_q;
	logic [15:0]      oper_q;
	logic [7:0]       rfAddr_q;
	apb_rsp_t         rsp_q;

	logic [7:0]       rdA;
	logic [7:0]       rdB;
	logic [7:0]       rotResult;
	rot_flags_t       rotFlags;

	assign apbRsp = rsp_q;

	// APB decode
	wire        busy      = (state_q != S_IDLE);
	wire        access    = apbReq.psel & apbReq.penable;
	wire [7:0]  addr      = apbReq.paddr;
	wire [31:0] wdata     = apbReq.pwdata;
	wire        hitCtrl   = (addr == ADDR_CTRL);
	wire        hitOper   = (addr == ADDR_OPER);
	wire        hitFlags  = (addr == ADDR_FLAGS);
	wire        hitSp     = (addr == ADDR_SP);
	wire        hitPc     = (addr == ADDR_PC);
	wire        hitStatus = (addr == ADDR_STATUS);
	wire        hitRfAddr = (addr == ADDR_RFADDR);
	wire        hitRfData = (addr == ADDR_RFDATA);
	wire        mapped    = hitCtrl | hitOper | hitFlags | hitSp | hitPc
	                      | hitStatus | hitRfAddr | hitRfData;
	wire        stall     = hitRfData & busy;
	wire        answerNow = access & ~rsp_q.pready & ~stall;
	wire        wrTake    = access & apbReq.pwrite & rsp_q.pready & mapped;
	wire        idleWr    = wrTake & ~busy;

	wire [31:0] statusWord = {29'h00000000, illegal_q, done_q, busy};
	wire [31:0] rdMux =
		hitCtrl   ? {24'h000000, ctrlOpc_q} :
		hitOper   ? {16'h0000, oper_q} :
		hitFlags  ? {24'h000000, flags_q} :
		hitSp     ? {16'h0000, stackPtr_q} :
		hitPc     ? {16'h0000, programCounter_q} :
		hitStatus ? statusWord :
		hitRfAddr ? {24'h000000, rfAddr_q} :
		hitRfData ? {24'h000000, rdA} : 32'h00000000;

	// start request and opcode screening
	wire [7:0]       startOpc  = wdata[7:0];
	wire             startReq  = wrTake & hitCtrl & wdata[CTRL_START] & ~busy;
	wire             stIsRot   = (startOpc[7:1] == OPC_ROT_L[7:1])
	                          | (startOpc[7:1] == OPC_ROT_LC[7:1])
	                          | (startOpc[7:1] == OPC_ROT_R[7:1])
	                          | (startOpc[7:1] == OPC_ROT_RC[7:1]);
	wire [CNT_W-1:0] startCyc  =
		(startOpc == OPC_PUSH_DN)  ? CYC_PUSH :
		(startOpc == OPC_PUSH_UP)  ? CYC_PUSH :
		(startOpc == OPC_CARRY_CL) ? CYC_CLR :
		(startOpc == SUB_EXIT_OPC) ? CYC_RET :
		stIsRot                    ? CYC_ROT : CYC_NONE;
	wire             startLegal = (startCyc != CYC_NONE);

	// decode of the opcode in flight
	wire isPushDn  = (opc_q == OPC_PUSH_DN);
	wire isPushUp  = (opc_q == OPC_PUSH_UP);
	wire isPush    = isPushDn | isPushUp;
	wire isClr     = (opc_q == OPC_CARRY_CL);
	wire isRet     = (opc_q == SUB_EXIT_OPC) & ~isClr;
	wire isRotL    = (opc_q[7:1] == OPC_ROT_L[7:1]);
	wire isRotLC   = (opc_q[7:1] == OPC_ROT_LC[7:1]);
	wire isRotR    = (opc_q[7:1] == OPC_ROT_R[7:1]);
	wire isRotRC   = (opc_q[7:1] == OPC_ROT_RC[7:1]);
	wire isRot     = isRotL | isRotLC | isRotR | isRotRC;
	wire indirect  = opc_q[0];
	wire inPtr     = (state_q == S_PTR);
	wire inExec    = (state_q == S_EXEC);

	rot_kind_t rotKind;
	assign rotKind = isRotL  ? ROT_LEFT :
	                 isRotLC ? ROT_LEFT_C :
	                 isRotR  ? ROT_RIGHT : ROT_RIGHT_C;

	// pointer arithmetic
	wire [7:0] spLow  = stackPtr_q[7:0];
	wire [7:0] spNext = 8'(spLow + 8'h01);
	wire [7:0] ptrDn  = 8'(rdA - 8'h01);
	wire [7:0] ptrUp  = 8'(rdA + 8'h01);
	wire [7:0] newPtr = isPushDn ? ptrDn : ptrUp;

	// register file port steering
	wire [7:0] engAddrA = inPtr ? (isRet ? spLow : dstOp_q)
	                            : (isRet ? spNext : ptr_q);
	wire [7:0] rdAddrA  = busy ? engAddrA : rfAddr_q;
	wire       engWr    = (inPtr & isPush) | (inExec & (isPush | isRot));
	wire       apbRfWr  = idleWr & hitRfData;
	wire       rfWrEn   = busy ? engWr : apbRfWr;
	wire [7:0] rfWrAddr = busy ? (inPtr ? dstOp_q : ptr_q) : rfAddr_q;
	wire [7:0] engData  = inPtr ? newPtr : (isPush ? rdB : rotResult);
	wire [7:0] rfWrData = busy ? engData : wdata[7:0];

	user_reg_file #(
		.AW    (RF_AW),
		.WIDTH (RF_W)
	) regFile (
		.mclk    (mclk),
		.wrEn    (rfWrEn),
		.wrAddr  (rfWrAddr),
		.wrData  (rfWrData),
		.rdAddrA (rdAddrA),
		.rdDataA (rdA),
		.rdAddrB (srcOp_q),
		.rdDataB (rdB)
	);

	rotate_unit rotor (
		.kind    (rotKind),
		.operand (rdA),
		.carryIn (flags_q[FLAG_C]),
		.result  (rotResult),
		.flags   (rotFlags)
	);

	// APB answer: one cycle into the access phase, held off on stall;
	// error and data stand only while pready does
	apb_rsp_t   rsp_d;
	wire [31:0] answerData = apbReq.pwrite ? 32'h00000000 : rdMux;
	assign rsp_d.pready  = answerNow;
	assign rsp_d.pslverr = answerNow & ~mapped;
	assign rsp_d.prdata  = answerNow ? answerData : 32'h00000000;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rsp_q <= '0;
		else
			rsp_q <= rsp_d;
	end

	// software-written set-up registers
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrlOpc_q <= 8'h00;
			oper_q    <= OPER_RST;
			rfAddr_q  <= 8'h00;
		end
		else
		begin
			if (wrTake & hitCtrl)
				ctrlOpc_q <= startOpc;
			if (wrTake & hitOper)
				oper_q <= wdata[15:0];
			if (wrTake & hitRfAddr)
				rfAddr_q <= wdata[7:0];
		end
	end

	// sequencer
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_q <= S_IDLE;
			opc_q   <= 8'h00;
			dstOp_q <= 8'h00;
			srcOp_q <= 8'h00;
			cnt_q   <= CYC_NONE;
			ptr_q   <= 8'h00;
			pcHi_q  <= 8'h00;
		end
		else
		begin
			if (busy && cnt_q != CYC_NONE)
				cnt_q <= 4'(cnt_q - 4'h1);
			unique case (state_q)
				S_IDLE:
				begin
					if (startReq && startLegal)
					begin
						opc_q   <= startOpc;
						dstOp_q <= oper_q[7:0];
						srcOp_q <= oper_q[15:8];
						cnt_q   <= 4'(startCyc - 4'h1);
						state_q <= S_PTR;
					end
				end
				S_PTR:
				begin
					if (isPush)
						ptr_q <= newPtr;                    // [RULE_01] [RULE_02]
					else if (isRot)
						ptr_q <= indirect ? rdA : dstOp_q;  // [RULE_15]
					if (isRet)
						pcHi_q <= rdA;                      // [RULE_06]
					state_q <= isClr ? S_WAIT : S_EXEC;
				end
				S_EXEC:
					state_q <= S_WAIT;
				S_WAIT:
				begin
					if (cnt_q == CYC_NONE)
						state_q <= S_IDLE;
				end
			endcase
		end
	end

	// next flag byte; pushes and exit fall through to hold [RULE_03]
	// rotates rewrite C Z S V only; D, H and spare bits hold
	wire        clrCarry  = inPtr & isClr;
	wire        rotUpdate = inExec & isRot;
	wire        swFlags   = idleWr & hitFlags;
	logic [7:0] flagsClr;
	logic [7:0] flagsRot;

	always_comb
	begin
		flagsClr         = flags_q;
		flagsClr[FLAG_C] = 1'b0;                  // [RULE_04]
		flagsRot         = flags_q;               // [RULE_14]
		flagsRot[FLAG_C] = rotFlags.carry;        // [RULE_07] [RULE_08]
		flagsRot[FLAG_Z] = rotFlags.zero;         // [RULE_11]
		flagsRot[FLAG_S] = rotFlags.sign;         // [RULE_12]
		flagsRot[FLAG_V] = rotFlags.overflow;     // [RULE_13]
	end

	wire [7:0] flags_d = clrCarry  ? flagsClr :
	                     rotUpdate ? flagsRot :
	                     swFlags   ? wdata[7:0] : flags_q;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			flags_q <= FLAGS_RST;
		else
			flags_q <= flags_d;
	end

	// exit pops the counter and steps the pointer past both bytes
	wire        popping = inExec & isRet;
	wire        swSp    = idleWr & hitSp;
	wire        swPc    = idleWr & hitPc;
	wire [15:0] stackPtr_d =
		popping ? 16'(stackPtr_q + {8'h00, SP_STEP}) :  // [RULE_05]
		swSp    ? wdata[15:0] : stackPtr_q;
	wire [15:0] programCounter_d =
		popping ? {pcHi_q, rdA} :                      // [RULE_05] [RULE_06]
		swPc    ? wdata[15:0] : programCounter_q;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			stackPtr_q       <= SP_RST;
			programCounter_q <= PC_RST;
		end
		else
		begin
			stackPtr_q       <= stackPtr_d;
			programCounter_q <= programCounter_d;
		end
	end

	// completion and illegal-opcode flags; a new set beats a clear
	wire finishing  = (state_q == S_WAIT) && (cnt_q == CYC_NONE);
	wire badStart   = startReq & ~startLegal;
	wire statClr    = wrTake & hitStatus;
	wire doneSet    = finishing | badStart;
	wire doneClr    = statClr & wdata[STAT_DONE];
	wire illegalClr = statClr & wdata[STAT_ILLEGAL];

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			done_q    <= 1'b0;
			illegal_q <= 1'b0;
		end
		else
		begin
			if (doneSet)
				done_q <= 1'b1;
			else if (doneClr)
				done_q <= 1'b0;
			if (badStart)
				illegal_q <= 1'b1;
			else if (illegalClr)
				illegal_q <= 1'b0;
		end
	end

endmodule

// File: tb/rotate_stack_instr_exec_assertions.sv
// checker: bus-level assertions on the exec block ports
// assumes the master holds each request until pready
`timescale 1ns/1ps
module rotate_stack_instr_exec_assertions
	import rotate_stack_pkg::*;
(
	input wire logic     mclk,
	input wire logic     rst_n,
	input wire apb_req_t apbReq,
	input wire apb_rsp_t apbRsp
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire logic rdy = apbRsp.pready;
	wire logic rdRdy = rdy && !apbReq.pwrite;
	wire logic mapped = apbReq.paddr[1:0] == 2'h0 && apbReq.paddr <= 8'h1C;
	wire logic narrow = apbReq.paddr inside {ADDR_CTRL, ADDR_FLAGS, ADDR_RFADDR};

	a_ready_pulse: assert property (rdy |=> !rdy)
		else $error("pready held too long");
	a_ready_access: assert property (rdy |-> apbReq.psel && apbReq.penable)
		else $error("pready outside access");
	a_one_wait: assert property ($rose(apbReq.penable) && apbReq.psel
		&& apbReq.paddr != ADDR_RFDATA |=> rdy)
		else $error("wait state count wrong");
	a_err_unmapped: assert property (rdy && !mapped |-> apbRsp.pslverr)
		else $error("no error on unmapped address");
	a_err_mapped: assert property (rdy && mapped |-> !apbRsp.pslverr)
		else $error("error on mapped address");
	a_write_zero: assert property (rdy && apbReq.pwrite |-> apbRsp.prdata == 32'h0)
		else $error("read data on write");
	a_err_data: assert property (apbRsp.pslverr |-> rdy && apbRsp.prdata == 32'h0)
		else $error("bad error response");
	a_status_upper: assert property (rdRdy && apbReq.paddr == ADDR_STATUS
		|-> apbRsp.prdata[31:3] == 29'h0)
		else $error("status upper bits set");
	a_byte_upper: assert property (rdRdy && narrow |-> apbRsp.prdata[31:8] == 24'h0)
		else $error("byte register upper bits set");
	a_reset_quiet: assert property ($rose(rst_n) |-> !rdy && !apbRsp.pslverr)
		else $error("response right after reset");
endmodule

bind rotate_stack_instr_exec rotate_stack_instr_exec_assertions chk (
	.mclk(mclk),
	.rst_n(rst_n),
	.apbReq(apbReq),
	.apbRsp(apbRsp)
);

// File: tb/rotate_stack_instr_exec_tb.sv
// testbench: runs the instructions over APB and checks the results
// assumes the exit opcode parameter is set to EXIT_OPC below
`timescale 1ns/1ps
module rotate_stack_instr_exec_tb import rotate_stack_pkg::*;;
	localparam logic [7:0] EXIT_OPC = 8'hCE; // arbitrary code
	logic        mclk;
	logic        rst_n;
	apb_req_t    apbReq;
	apb_rsp_t    apbRsp;
	int          mismatches;
	int          nTests;
	logic [31:0] rd;
	logic        err;

	rotate_stack_instr_exec #(.SUB_EXIT_OPC(EXIT_OPC)) DUT (
		.mclk(mclk),
		.rst_n(rst_n),
		.apbReq(apbReq),
		.apbRsp(apbRsp)
	);

	task automatic end_sim();
		$display("mismatches %0d checks %0d", mismatches, nTests);
		if (mismatches == 0 && nTests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic fail();
		mismatches++;
		end_sim();
	endtask
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		nTests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		apbReq.penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge mclk);
			i++;
		end while (apbRsp.pready !== 1'b1 && i < 40);
		if (apbRsp.pready !== 1'b1)
			fail();
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask
	task automatic setrf(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, ADDR_RFADDR, {24'h0, a});
		bus(1'b1, ADDR_RFDATA, {24'h0, d});
	endtask
	task automatic getrf(input logic [7:0] a);
		bus(1'b1, ADDR_RFADDR, {24'h0, a});
		bus(1'b0, ADDR_RFDATA, 32'h0);
	endtask
	task automatic waitdone();
		int i;
		i = 0;
		do
		begin
			bus(1'b0, ADDR_STATUS, 32'h0);
			i++;
		end while (rd[STAT_DONE] !== 1'b1 && i < 20);
		if (rd[STAT_DONE] !== 1'b1)
			fail();
		bus(1'b1, ADDR_STATUS, 32'h6);
	endtask
	task automatic exec(input logic [7:0] opc, input logic [15:0] op);
		bus(1'b1, ADDR_OPER, {16'h0, op});
		bus(1'b1, ADDR_CTRL, {23'h0, 1'b1, opc});
		waitdone();
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(nm, exp, rd);
	endtask

	task automatic t_reset();
		rdchk("flags", ADDR_FLAGS, 32'h0);
		rdchk("sp", ADDR_SP, 32'h0);
		rdchk("pc", ADDR_PC, 32'h0);
		bus(1'b1, 8'h40, 32'h5);
		check("unmapped err", 32'h1, {31'h0, err});
		$display("reset test done");
	endtask
	task automatic t_push();
		setrf(8'h00, 8'h03);
		setrf(8'h01, 8'h05);
		bus(1'b1, ADDR_FLAGS, 32'hFC);
		exec(OPC_PUSH_DN, 16'h0100);
		getrf(8'h00);
		check("ptr down", 32'h02, rd);
		getrf(8'h02);
		check("stored down", 32'h05, rd);
		setrf(8'h01, 8'h77);
		exec(OPC_PUSH_UP, 16'h0100);
		getrf(8'h00);
		check("ptr up", 32'h03, rd);
		getrf(8'h03);
		check("stored up", 32'h77, rd);
		rdchk("push flags", ADDR_FLAGS, 32'hFC);
		$display("push test done");
	endtask
	task automatic t_clear();
		bus(1'b1, ADDR_FLAGS, 32'hFF);
		exec(OPC_CARRY_CL, 16'h0);
		rdchk("clear flags", ADDR_FLAGS, 32'h7F);
		exec(OPC_CARRY_CL, 16'h0);
		rdchk("clear again", ADDR_FLAGS, 32'h7F);
		$display("carry clear test done");
	endtask
	task automatic t_exit();
		setrf(8'hFC, 8'h10);
		setrf(8'hFD, 8'h1A);
		bus(1'b1, ADDR_SP, 32'hFC);
		bus(1'b1, ADDR_PC, 32'h1234);
		bus(1'b1, ADDR_FLAGS, 32'hA5);
		exec(EXIT_OPC, 16'h0);
		rdchk("exit pc", ADDR_PC, 32'h101A);
		rdchk("exit sp", ADDR_SP, 32'hFE);
		rdchk("exit flags", ADDR_FLAGS, 32'hA5);
		setrf(8'hFF, 8'hC3);
		bus(1'b1, ADDR_SP, 32'h01FF);
		exec(EXIT_OPC, 16'h0);
		rdchk("wrap pc", ADDR_PC, 32'hC303);
		rdchk("wrap sp", ADDR_SP, 32'h0201);
		$display("exit test done");
	endtask
	task automatic t_rot();
		logic [7:0] opc [4];
		logic [7:0] v [3];
		logic [7:0] f [3];
		logic [7:0] r;
		logic [7:0] e;
		opc = '{OPC_ROT_L, OPC_ROT_LC, OPC_ROT_R, OPC_ROT_RC};
		v = '{8'hAA, 8'h00, 8'h81};
		f = '{8'h0C, 8'hF3, 8'h8C};
		for (int k = 0; k < 4; k++)
			for (int j = 0; j < 3; j++)
			begin
				setrf(8'h20, v[j]);
				setrf(8'h21, 8'h20);
				bus(1'b1, ADDR_FLAGS, {24'h0, f[j]});
				exec(opc[k] | {7'h0, j[0]}, {8'h0, 7'h10, j[0]});
				r = k < 2 ? {v[j][6:0], k[0] ? f[j][FLAG_C] : v[j][7]}
					: {k[0] ? f[j][FLAG_C] : v[j][0], v[j][7:1]};
				e = f[j];
				e[FLAG_C] = k < 2 ? v[j][7] : v[j][0];
				e[FLAG_Z] = r == 8'h00;
				e[FLAG_S] = r[7];
				e[FLAG_V] = r[7] ^ v[j][7];
				getrf(8'h20);
				check("rot result", {24'h0, r}, rd);
				rdchk("rot flags", ADDR_FLAGS, {24'h0, e});
				getrf(8'h21);
				check("rot pointer", 32'h20, rd);
			end
		$display("rotate test done");
	endtask
	task automatic t_status();
		bus(1'b1, ADDR_FLAGS, 32'h81);
		bus(1'b1, ADDR_CTRL, {23'h0, 1'b1, 8'h42});
		rdchk("illegal status", ADDR_STATUS, 32'h6);
		rdchk("illegal flags", ADDR_FLAGS, 32'h81);
		bus(1'b1, ADDR_STATUS, 32'h6);
		rdchk("status clear", ADDR_STATUS, 32'h0);
		bus(1'b1, ADDR_CTRL, {23'h0, 1'b1, OPC_CARRY_CL});
		rdchk("busy status", ADDR_STATUS, 32'h1);
		waitdone();
		rdchk("late flags", ADDR_FLAGS, 32'h01);
		$display("status test done");
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial
	begin
		rst_n = 1'b0;
		apbReq = '0;
		mismatches = 0;
		nTests = 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_push();
		t_clear();
		t_exit();
		t_rot();
		t_status();
		end_sim();
	end
endmodule
